// ===== rtl/tpse_encoder.sv
// PWM temperature encoder with status slot, clamped registers and relay comparator.
// Assumes an APB master on pclk; temperatures arrive as signed sixteenths of a degree.
`timescale 1ns/1ps
`default_nettype none
`include "tpse_defs.svh"

module tpse_encoder
  import tpse_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `TPSE_TICK_CYCLES
)
(
  // APB clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // Measured temperatures, signed sixteenths of a degree
  input  wire logic [15:0] object_temp,
  input  wire logic [15:0] ambient_temp,
  // Consistency check result from the calibration store
  input  wire logic        eeprom_check_fail,
  // Outputs
  output var  logic        object_pwm,
  output var  logic        ambient_pwm,
  output var  logic        relay_drive_output,
  output var  logic        relay_drive_oe
);

  // Synchronisers for the asynchronous inputs.
  logic [15:0] obj_s1, obj_s2, obj_s3;
  logic [15:0] amb_s1, amb_s2, amb_s3;
  logic [2:0]  fail_s;
  logic [15:0] obj_t;
  logic [15:0] amb_t;
  logic        fail_t;

  // A word is taken only when two stages agree, so a value caught mid-change is never used.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      obj_s1 <= 16'h0000;
      obj_s2 <= 16'h0000;
      obj_s3 <= 16'h0000;
      obj_t  <= 16'h0000;
    end
    else
    begin
      obj_s1 <= object_temp;
      obj_s2 <= obj_s1;
      obj_s3 <= obj_s2;
      if (obj_s2 == obj_s3)
        obj_t <= obj_s3;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      amb_s1 <= 16'h0000;
      amb_s2 <= 16'h0000;
      amb_s3 <= 16'h0000;
      amb_t  <= 16'h0000;
    end
    else
    begin
      amb_s1 <= ambient_temp;
      amb_s2 <= amb_s1;
      amb_s3 <= amb_s2;
      if (amb_s2 == amb_s3)
        amb_t <= amb_s3;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fail_s <= 3'h0;
      fail_t <= 1'b0;
    end
    else
    begin
      fail_s <= {fail_s[1:0], eeprom_check_fail};
      if (fail_s[1] == fail_s[2])
        fail_t <= fail_s[2];
    end
  end

  // Control register written by software, and the temperature registers it reads back.
  logic [31:0]     ctrl;
  tpse_temp_reg_t  obj_reg;
  tpse_temp_reg_t  amb_reg;
  tpse_apb_state_t apb_state;
  logic            fatal;

  assign fatal = fail_t | ctrl[`TPSE_CTRL_FATAL_BIT];

  // Scaling: value = (T - Tmin) * 4095 / (Tmax - Tmin), with range clamps.
  function automatic logic [11:0] tpse_scale(input logic signed [15:0] t,
                                             input logic signed [15:0] tmin,
                                             input logic signed [15:0] tmax);
    logic signed [31:0] num;
    logic signed [31:0] den;
    logic        [31:0] q;
    num = (32'(t) - 32'(tmin)) * 32'sd4095;
    den = 32'(tmax) - 32'(tmin);
    q   = 32'(num / den);
    if (t <= tmin)
      tpse_scale = `TPSE_DATA_MIN;
    else if (t >= tmax)
      tpse_scale = `TPSE_DATA_MAX;
    else
      tpse_scale = q[11:0];
  endfunction : tpse_scale

  logic signed [15:0] obj_sv;
  logic signed [15:0] amb_sv;
  logic               amb_under;
  logic               amb_over;
  logic        [11:0] next_obj_data;
  logic        [11:0] next_amb_data;

  assign obj_sv    = obj_t;
  assign amb_sv    = amb_t;
  assign amb_under = amb_sv < `TPSE_AMB_MIN_C;
  assign amb_over  = amb_sv > `TPSE_AMB_MAX_C;

  always_comb
  begin
    next_obj_data = tpse_scale(obj_sv, `TPSE_OBJ_MIN_C, `TPSE_OBJ_MAX_C);
    next_amb_data = tpse_scale(amb_sv, `TPSE_AMB_MIN_C, `TPSE_AMB_MAX_C);
    if (amb_under)
    begin
      next_obj_data = `TPSE_DATA_MIN;
      next_amb_data = `TPSE_DATA_MIN;
    end
    else if (amb_over)
    begin
      next_obj_data = `TPSE_DATA_MAX;
      next_amb_data = `TPSE_DATA_MAX;
    end
  end

  // Registers follow the measurement continuously; PWM latches separately.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      obj_reg <= '0;
      amb_reg <= '0;
    end
    else
    begin
      obj_reg <= '{data: next_obj_data, overflow: amb_over, underflow: amb_under,
                   fatal: fatal, zero: 1'b0};
      amb_reg <= '{data: next_amb_data, overflow: amb_over, underflow: amb_under,
                   fatal: fatal, zero: 1'b0};
    end
  end

  // Tick prescaler and frame counter.
  logic [15:0] prescale;
  logic        tick;
  logic [10:0] frame_pos;

  assign tick = prescale == 16'(TICK_CYCLES - 1);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prescale <= 16'h0000;
    else if (tick)
      prescale <= 16'h0000;
    else
      prescale <= prescale + 16'h0001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      frame_pos <= 11'h000;
    else if (tick)
      frame_pos <= frame_pos + 11'h001;
  end

  // High time in ticks from frame start for each channel.
  function automatic logic [10:0] tpse_high(input logic [11:0] data,
                                            input logic under,
                                            input logic over,
                                            input logic fe);
    if (fe)
      tpse_high = `TPSE_HIGH_FATAL;
    else if (over)
      tpse_high = `TPSE_HIGH_OVERFLOW;
    else if (under)
      tpse_high = `TPSE_HIGH_UNDERFLOW;
    else
      tpse_high = `TPSE_BUF_END + {1'b0, data[11:2]};
  endfunction : tpse_high

  logic [10:0] obj_high;
  logic [10:0] amb_high;
  logic        frame_end;

  // The last tick of a frame is the only point where a new duty may be taken.
  assign frame_end = tick && (frame_pos == `TPSE_FRAME_LAST);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      obj_high <= `TPSE_BUF_END;
    else if (frame_end)
      obj_high <= tpse_high(next_obj_data, amb_under, amb_over, fatal);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      amb_high <= `TPSE_BUF_END;
    else if (frame_end)
      amb_high <= tpse_high(next_amb_data, amb_under, amb_over, fatal);
  end

  // Buffer forces high; otherwise high until the latched high time.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      object_pwm <= 1'b0;
    else
      object_pwm <= (frame_pos < `TPSE_BUF_END) || (frame_pos < obj_high);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ambient_pwm <= 1'b0;
    else
      ambient_pwm <= (frame_pos < `TPSE_BUF_END) || (frame_pos < amb_high);
  end

  // Relay comparator with hysteresis; the active state means temperature is high.
  logic               rel_hot;
  logic signed [15:0] rel_src;

  assign rel_src = ctrl[`TPSE_CTRL_SRC_BIT] ? amb_sv : obj_sv;

  // Hysteresis keeps the relay from chattering while the source sits at the threshold.

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rel_hot <= 1'b0;
    else if (rel_src > `TPSE_REL_THRESH_C)
      rel_hot <= 1'b1;
    else if (rel_src < (`TPSE_REL_THRESH_C - `TPSE_REL_HYST_C))
      rel_hot <= 1'b0;
  end

  // Open drain: pulling low means the relay is on.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      relay_drive_oe <= 1'b0;
    else
      relay_drive_oe <= ctrl[`TPSE_CTRL_POL_BIT] ? rel_hot : !rel_hot;
  end

  // The pin only ever pulls low; an outside pull-up gives the released level.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      relay_drive_output <= 1'b0;
    else
      relay_drive_output <= 1'b0;
  end

  // APB slave: one wait-free access phase, unmapped addresses flag an error.
  logic        mapped;
  logic [31:0] rd_mux;

  always_comb
  begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      `TPSE_ADDR_CTRL:    rd_mux = ctrl;
      `TPSE_ADDR_OBJ_IN:  rd_mux = {16'h0000, obj_t};
      `TPSE_ADDR_AMB_IN:  rd_mux = {16'h0000, amb_t};
      `TPSE_ADDR_OBJ_REG: rd_mux = {16'h0000, obj_reg};
      `TPSE_ADDR_AMB_REG: rd_mux = {16'h0000, amb_reg};
      `TPSE_ADDR_STATUS:  rd_mux = {27'h0, rel_hot, fatal, amb_over, amb_under, frame_end};
      default:            mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      apb_state <= TPSE_IDLE;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      prdata    <= 32'h0000_0000;
    end
    else
    begin
      unique case (apb_state)
        TPSE_IDLE:
        begin
          pready  <= 1'b0;
          pslverr <= 1'b0;
          if (psel && !penable)
          begin
            apb_state <= TPSE_ACCESS;
            pready    <= 1'b1;
            pslverr   <= !mapped;
            prdata    <= pwrite ? 32'h0000_0000 : rd_mux;
          end
        end
        TPSE_ACCESS:
        begin
          apb_state <= TPSE_IDLE;
          pready    <= 1'b0;
          pslverr   <= 1'b0;
        end
        default:
          apb_state <= TPSE_IDLE;
      endcase
    end
  end

  // Writes take effect at the completing edge of the access phase.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl <= `TPSE_CTRL_RESET;
    else if (psel && penable && pready && pwrite && paddr == `TPSE_ADDR_CTRL)
      ctrl <= pwdata & 32'h0000_0007;
  end

endmodule : tpse_encoder
`default_nettype wire

// ===== rtl/tpse_defs.svh
// Constants for the thermometer PWM status encoder.
// Assumes a 100 MHz pclk and a PWM tick of 50 us derived from it.
`ifndef TPSE_DEFS_SVH
`define TPSE_DEFS_SVH
`define TPSE_CLK_PERIOD_NS    32'd10
`define TPSE_TICK_US          32'd50
`define TPSE_TICK_CYCLES      ((`TPSE_TICK_US * 32'd1000) / `TPSE_CLK_PERIOD_NS)
`define TPSE_FRAME_LAST       11'h7FF
`define TPSE_BUF_END          11'h100
`define TPSE_DATA_SPAN        11'h400
`define TPSE_HIGH_UNDERFLOW   11'h580
`define TPSE_HIGH_OVERFLOW    11'h600
`define TPSE_HIGH_FATAL       11'h680
`define TPSE_DATA_MAX         12'hFFF
`define TPSE_DATA_MIN         12'h000
`define TPSE_OBJ_MIN_C        16'shFEC0
`define TPSE_OBJ_MAX_C        16'sh0780
`define TPSE_AMB_MIN_C        16'sh0000
`define TPSE_AMB_MAX_C        16'sh0320
`define TPSE_REL_THRESH_C     16'sh0320
`define TPSE_REL_HYST_C       16'sh0050
`define TPSE_ADDR_CTRL        12'h000
`define TPSE_ADDR_OBJ_IN      12'h004
`define TPSE_ADDR_AMB_IN      12'h008
`define TPSE_ADDR_OBJ_REG     12'h00C
`define TPSE_ADDR_AMB_REG     12'h010
`define TPSE_ADDR_STATUS      12'h014
`define TPSE_CTRL_FATAL_BIT   0
`define TPSE_CTRL_SRC_BIT     1
`define TPSE_CTRL_POL_BIT     2
`define TPSE_CTRL_RESET       32'h0000_0000
`endif

// ===== rtl/tpse_pkg.sv
// Types for the thermometer PWM status encoder.
// Assumes nothing beyond the constants header.
package tpse_pkg;
  typedef enum logic [1:0]
  {
    TPSE_IDLE   = 2'b00,
    TPSE_ACCESS = 2'b01
  } tpse_apb_state_t;

  typedef struct packed
  {
    logic [11:0] data;
    logic        overflow;
    logic        underflow;
    logic        fatal;
    logic        zero;
  } tpse_temp_reg_t;
endpackage : tpse_pkg

// ===== dv/tpse_encoder_props.sv
// Port checker for the PWM status encoder.
// Assumes it is bound to tpse_encoder and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module tpse_encoder_props #(
  parameter int unsigned TICK_CYCLES = 2
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Outputs
  input wire logic object_pwm,
  input wire logic ambient_pwm,
  input wire logic relay_drive_output
);
  localparam int FRAME = 2048 * TICK_CYCLES;
  localparam int LO    = 32'h100 * TICK_CYCLES;
  localparam int HI    = 32'h680 * TICK_CYCLES;
  logic [15:0] cnt;
  logic        prev;
  logic        seen;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Restarting on each rise turns frame length into a plain compare.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt  <= 16'h0000;
      prev <= 1'b0;
      seen <= 1'b0;
    end
    else
    begin
      prev <= object_pwm;
      cnt  <= (object_pwm && !prev) ? 16'h0000 : cnt + 16'h0001;
      seen <= seen | (object_pwm && !prev);
    end
  end
  frame_len_a: assert property ($rose(object_pwm) && seen |-> cnt == 16'(FRAME - 1))
    else $error("frame length wrong");
  buffer_high_a: assert property ($rose(object_pwm) |-> ##300 object_pwm)
    else $error("leading buffer not high");
  obj_span_a: assert property ($fell(object_pwm) |-> cnt >= 16'(LO - 1) && cnt <= 16'(HI - 1))
    else $error("object high time out of span");
  amb_span_a: assert property ($fell(ambient_pwm) |-> cnt >= 16'(LO - 1) && cnt <= 16'(HI - 1))
    else $error("ambient high time out of span");
  tick_align_a: assert property ($fell(object_pwm) |-> (32'(cnt) + 1) % TICK_CYCLES == 0)
    else $error("fall off tick");
  frames_aligned_a: assert property ($rose(ambient_pwm) |-> $rose(object_pwm))
    else $error("outputs not frame aligned");
  ready_after_setup_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready not one pulse after setup");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  relay_low_a: assert property (!relay_drive_output)
    else $error("relay pin level not low");
endmodule : tpse_encoder_props
bind tpse_encoder tpse_encoder_props #(.TICK_CYCLES(TICK_CYCLES)) u_tpse_encoder_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .object_pwm(object_pwm), .ambient_pwm(ambient_pwm),
  .relay_drive_output(relay_drive_output));
`default_nettype wire

// ===== dv/tpse_mcu_capture.sv
// Timer capture model that measures PWM high time per frame.
// Assumes the PWM input is sampled on pclk.
`timescale 1ns/1ps
`default_nettype none
module tpse_mcu_capture
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Capture input and result
  input  wire logic        pwm_in,
  output var  logic [15:0] high_cycles
);
  logic [15:0] run_cnt;
  logic        last;
  // High time is latched on each fall, as a timer capture would do.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_cnt     <= 16'h0000;
      last        <= 1'b0;
      high_cycles <= 16'h0000;
    end
    else
    begin
      last    <= pwm_in;
      run_cnt <= (pwm_in && !last) ? 16'h0001 : run_cnt + 16'(pwm_in);
      if (!pwm_in && last)
        high_cycles <= run_cnt;
    end
  end
endmodule : tpse_mcu_capture
`default_nettype wire

// ===== dv/tb_tpse_encoder.sv
// Testbench for the PWM status encoder.
// Assumes the bound checker and one capture model on each PWM output.
`timescale 1ns/1ps
`default_nettype none
`include "tpse_defs.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module tb_tpse_encoder;
  localparam int unsigned TC = 2;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] object_temp, ambient_temp, obj_hi, amb_hi;
  logic        eeprom_check_fail, object_pwm, ambient_pwm, relay_drive_output, relay_drive_oe;
  int          error_cnt = 0;
  int          comparisons = 0;
  tpse_encoder #(.TICK_CYCLES(TC)) u_tpse_encoder (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .object_temp(object_temp),
    .ambient_temp(ambient_temp), .eeprom_check_fail(eeprom_check_fail),
    .object_pwm(object_pwm), .ambient_pwm(ambient_pwm),
    .relay_drive_output(relay_drive_output), .relay_drive_oe(relay_drive_oe));
  tpse_mcu_capture u_tpse_mcu_capture (.pclk(pclk), .presetn(presetn),
    .pwm_in(object_pwm), .high_cycles(obj_hi));
  tpse_mcu_capture u_tpse_mcu_capture_amb (.pclk(pclk), .presetn(presetn),
    .pwm_in(ambient_pwm), .high_cycles(amb_hi));
  task automatic conclude();
    if (error_cnt == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Two frames are waited because a new duty only lands at a frame boundary.
  task automatic run(input logic [15:0] ot, at, input logic f, input logic [15:0] eo, ea, ro, ra);
    @(posedge pclk);
    object_temp       <= ot;
    ambient_temp      <= at;
    eeprom_check_fail <= f;
    repeat (2 * 2048 * TC + 16) @(posedge pclk);
    `CHK(obj_hi, 16'(eo * TC))
    `CHK(amb_hi, 16'(ea * TC))
    apb(1'b0, `TPSE_ADDR_OBJ_REG, 32'h0);
    `CHK(rd, {16'h0000, ro})
    apb(1'b0, `TPSE_ADDR_AMB_REG, 32'h0);
    `CHK(rd, {16'h0000, ra})
  endtask : run
  task automatic relay(input logic [15:0] ot, input logic e);
    @(posedge pclk);
    object_temp <= ot;
    repeat (40) @(posedge pclk);
    `CHK(relay_drive_oe, e)
  endtask : relay
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial
  begin
    repeat (90000) @(posedge pclk);
    error_cnt++;
    conclude();
  end
  initial
  begin
    {presetn, psel, penable, pwrite, eeprom_check_fail} = 5'h00;
    {paddr, pwdata} = 44'h0;
    {object_temp, ambient_temp} = 32'h0190_0190;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `TPSE_ADDR_CTRL, 32'h0);
    `CHK(rd, `TPSE_CTRL_RESET)
    apb(1'b0, 12'h100, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    run(16'h0780, 16'h0320, 1'b0, 16'h04FF, 16'h04FF, 16'hFFF0, 16'hFFF0);
    run(16'hFEC0, 16'h0000, 1'b0, 16'h0100, 16'h0100, 16'h0000, 16'h0000);
    run(16'hFE20, 16'h0320, 1'b0, 16'h0100, 16'h04FF, 16'h0000, 16'hFFF0);
    run(16'h0820, 16'h0000, 1'b0, 16'h04FF, 16'h0100, 16'hFFF0, 16'h0000);
    run(16'h0780, 16'hFFF0, 1'b0, 16'h0580, 16'h0580, 16'h0004, 16'h0004);
    run(16'hFE20, 16'h0330, 1'b0, 16'h0600, 16'h0600, 16'hFFF8, 16'hFFF8);
    run(16'h0780, 16'h0330, 1'b1, 16'h0680, 16'h0680, 16'hFFFA, 16'hFFFA);
    run(16'hFEC0, 16'h0000, 1'b0, 16'h0100, 16'h0100, 16'h0000, 16'h0000);
    apb(1'b1, `TPSE_ADDR_CTRL, 32'h1);
    run(16'hFEC0, 16'h0000, 1'b0, 16'h0680, 16'h0680, 16'h0002, 16'h0002);
    apb(1'b1, `TPSE_ADDR_CTRL, 32'h0);
    relay(16'h03C0, 1'b0);
    relay(16'h02F0, 1'b0);
    relay(16'h0280, 1'b1);
    apb(1'b1, `TPSE_ADDR_CTRL, 32'h4);
    relay(16'h03C0, 1'b1);
    apb(1'b1, `TPSE_ADDR_CTRL, 32'h6);
    relay(16'h03C0, 1'b0);
    apb(1'b0, `TPSE_ADDR_CTRL, 32'h0);
    `CHK(rd, 32'h6)
    conclude();
  end
endmodule : tb_tpse_encoder
`default_nettype wire
